// >>> rtl/apd_pkg.sv
// ==========================================================================
// shared constants and types of the addressing and prebyte decoder
package apd_pkg;

  // ========================================================================
  // instruction set figures
  localparam int          NUM_INSTR   = 63;
  localparam int          MAX_LEN     = 4;
  localparam logic [15:0] RESET_PC    = 16'h0000;

  // ========================================================================
  // prebyte values and the rcall opcode
  localparam logic [7:0]  PRE_Y_VAL   = 8'h90;
  localparam logic [7:0]  PRE_IY_VAL  = 8'h91;
  localparam logic [7:0]  PRE_IND_VAL = 8'h92;
  localparam logic [7:0]  OPC_RCALL   = 8'h93;

  // ========================================================================
  // opcode groups (upper nibble)
  localparam logic [3:0]  G_BTB       = 4'h0;
  localparam logic [3:0]  G_BIT       = 4'h1;
  localparam logic [3:0]  G_REL       = 4'h2;
  localparam logic [3:0]  G_RMW_DIR   = 4'h3;
  localparam logic [3:0]  G_RMW_A     = 4'h4;
  localparam logic [3:0]  G_RMW_X     = 4'h5;
  localparam logic [3:0]  G_RMW_IDXS  = 4'h6;
  localparam logic [3:0]  G_RMW_IDX0  = 4'h7;
  localparam logic [3:0]  G_MISC      = 4'h8;
  localparam logic [3:0]  G_PRE       = 4'h9;
  localparam logic [3:0]  G_ALU_IMM   = 4'ha;
  localparam logic [3:0]  G_ALU_DIRS  = 4'hb;
  localparam logic [3:0]  G_ALU_DIRL  = 4'hc;
  localparam logic [3:0]  G_ALU_IDXL  = 4'hd;
  localparam logic [3:0]  G_ALU_IDXS  = 4'he;
  localparam logic [3:0]  G_ALU_IDX0  = 4'hf;

  // ========================================================================
  // operation codes (lower nibble)
  localparam logic [3:0]  ALU_LAST    = 4'h9;
  localparam logic [3:0]  RMW_LAST    = 4'hb;
  localparam logic [3:0]  MISC_LAST   = 4'hd;
  localparam logic [3:0]  OP_JP       = 4'hc;
  localparam logic [3:0]  OP_CALL     = 4'hd;
  localparam logic [3:0]  OP_LDX_IMM  = 4'he;
  localparam logic [3:0]  OP_CPX_IMM  = 4'hf;

  typedef enum logic [1:0] {PF_NONE, PF_Y, PF_IND, PF_IND_Y} apd_pre_t;

  typedef enum logic [1:0] {BS_ZERO, BS_B1, BS_B1B2, BS_PTR} apd_base_t;

  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L, M_IND_S, M_IND_L,
    M_IIX_S, M_IIX_L, M_REL_D, M_REL_I, M_BIT_D, M_BIT_I, M_BTB_D, M_BTB_I
  } apd_mode_t;

  typedef enum logic [2:0] {S_OP, S_DEC, S_OPND, S_PTR, S_FIN, S_OUT, S_TRAP} apd_state_t;

endpackage : apd_pkg

// >>> rtl/apd_ea_adder.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// effective address and branch target arithmetic
module apd_ea_adder (
  input  wire logic [15:0] i_base,
  input  wire logic [7:0]  i_idx,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_ofs,
  output logic      [15:0] o_ea,
  output logic      [15:0] o_target
);
  // unsigned index add; a short base plus index tops out at 1fe
  assign o_ea     = i_base + {8'h00, i_idx};
  // signed 8-bit displacement on the address of the next instruction
  assign o_target = i_pc + {{8{i_ofs[7]}}, i_ofs};

endmodule : apd_ea_adder
`default_nettype wire

// >>> rtl/apd_opclass.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// opcode classifier: mode, index choice, legality, prebyte acceptance
module apd_opclass
  import apd_pkg::*;
(
  input  wire logic [7:0] i_opc,
  input  wire apd_pkg::apd_pre_t i_pre,
  output apd_pkg::apd_mode_t o_mode,
  output logic            o_use_y,
  output logic            o_legal,
  output logic            o_unauth
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic       ok_y;
  logic       ok_ind;
  logic       ok_iy;
  logic       ind;
  logic       acc;

  assign hi  = i_opc[7:4];
  assign lo  = i_opc[3:0];
  assign ind = (i_pre == PF_IND) || (i_pre == PF_IND_Y);

  always_comb begin
    o_mode = M_INH;
    o_legal = 1'b0;
    ok_y = 1'b0;
    ok_ind = 1'b0;
    ok_iy = 1'b0;
    // long forms exist only for the alu class; rmw, bit and jumps stay short
    case (hi)
      G_BTB:      begin o_legal = 1'b1; ok_ind = 1'b1; o_mode = ind ? M_BTB_I : M_BTB_D; end
      G_BIT:      begin o_legal = 1'b1; ok_ind = 1'b1; o_mode = ind ? M_BIT_I : M_BIT_D; end
      G_REL:      begin o_legal = 1'b1; ok_ind = 1'b1; o_mode = ind ? M_REL_I : M_REL_D; end
      G_RMW_DIR:  begin o_legal = (lo <= RMW_LAST); ok_ind = 1'b1; o_mode = ind ? M_IND_S : M_DIR_S; end
      G_RMW_A:    begin o_legal = (lo <= RMW_LAST); end
      G_RMW_X:    begin o_legal = (lo <= RMW_LAST); ok_y = 1'b1; end
      G_RMW_IDXS: begin
        o_legal = (lo <= RMW_LAST);
        {ok_y, ok_ind, ok_iy} = 3'b111;
        o_mode = ind ? M_IIX_S : M_IDX_S;
      end
      G_RMW_IDX0: begin o_legal = (lo <= RMW_LAST); ok_y = 1'b1; o_mode = M_IDX_0; end
      G_MISC:     begin o_legal = (lo <= MISC_LAST); end
      // a prebyte met here is legal but never accepted after another one
      G_PRE:      begin
        o_legal = (i_opc <= OPC_RCALL) && (i_pre != PF_NONE || i_opc == OPC_RCALL);
        ok_ind = (i_opc == OPC_RCALL);
        o_mode = ind ? M_REL_I : M_REL_D;
      end
      G_ALU_IMM:  begin
        o_legal = (lo <= ALU_LAST) || (lo == OP_LDX_IMM) || (lo == OP_CPX_IMM);
        ok_y = (lo == OP_LDX_IMM) || (lo == OP_CPX_IMM);
        o_mode = M_IMM;
      end
      G_ALU_DIRS: begin o_legal = (lo <= ALU_LAST) || (lo == OP_JP) || (lo == OP_CALL);
                        ok_ind = 1'b1; o_mode = ind ? M_IND_S : M_DIR_S; end
      G_ALU_DIRL: begin o_legal = (lo <= ALU_LAST); ok_ind = 1'b1; o_mode = ind ? M_IND_L : M_DIR_L; end
      G_ALU_IDXL: begin o_legal = (lo <= ALU_LAST); {ok_y, ok_ind, ok_iy} = 3'b111;
                        o_mode = ind ? M_IIX_L : M_IDX_L; end
      G_ALU_IDXS: begin o_legal = (lo <= ALU_LAST) || (lo == OP_JP) || (lo == OP_CALL);
                        {ok_y, ok_ind, ok_iy} = 3'b111; o_mode = ind ? M_IIX_S : M_IDX_S; end
      default:    begin o_legal = (lo <= ALU_LAST) || (lo == OP_JP) || (lo == OP_CALL);
                        ok_y = 1'b1; o_mode = M_IDX_0; end
    endcase
    acc = (i_pre == PF_NONE) || ((i_pre == PF_Y) && ok_y)
        || ((i_pre == PF_IND) && ok_ind) || ((i_pre == PF_IND_Y) && ok_iy);
    o_unauth = o_legal && !acc;
  end

  assign o_use_y = (i_pre == PF_Y) || (i_pre == PF_IND_Y);

endmodule : apd_opclass
`default_nettype wire

// >>> rtl/apd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// instruction fetch, prebyte handling and effective address sequencing

module apd_decoder
  import apd_pkg::*;
#(
  parameter logic [15:0] START_PC = RESET_PC
) (
  input  wire logic          I_CLK,
  input  wire logic          I_SYS_RST,
  output logic               O_MEM_REQ,
  output logic      [15:0]   O_MEM_ADDR,
  input  wire logic          I_MEM_ACK,
  input  wire logic [7:0]    I_MEM_RDATA,
  input  wire logic [7:0]    I_X,
  input  wire logic [7:0]    I_Y,
  input  wire logic          I_PC_LOAD,
  input  wire logic [15:0]   I_PC_VALUE,
  input  wire logic          I_EXEC_READY,
  output logic               O_DEC_VALID,
  output logic      [7:0]    O_DEC_OPCODE,
  output apd_pkg::apd_mode_t O_DEC_MODE,
  output logic               O_DEC_USE_Y,
  output logic      [15:0]   O_DEC_EA,
  output logic      [7:0]    O_DEC_OPERAND,
  output logic      [15:0]   O_DEC_TARGET,
  output logic      [15:0]   O_DEC_NEXT_PC,
  output logic      [2:0]    O_DEC_LEN,
  output logic               O_DEC_UNAUTH,
  output logic               O_ILLEGAL_RST
);

  // ========================================================================
  // state record
  typedef struct packed {
    apd_state_t  st;
    logic [15:0] pc;
    logic [15:0] addr;
    apd_pre_t    pre;
    logic [7:0]  opc;
    logic [1:0]  cnt;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  p_hi;
    logic [7:0]  p_lo;
    apd_mode_t   mode;
    logic        use_y;
    logic [2:0]  len;
    logic        valid;
    logic [15:0] ea;
    logic [15:0] target;
    logic        unauth;
    logic        ill;
  } apd_dec_state_t;

  apd_dec_state_t cur;
  apd_dec_state_t next_s;

  // every field spelled out, so no enum member is left to a blanket fill
  localparam apd_dec_state_t IDLE_STATE = '{
    st:     S_OP,
    pc:     START_PC,
    addr:   START_PC,
    pre:    PF_NONE,
    opc:    8'h00,
    cnt:    2'h0,
    b1:     8'h00,
    b2:     8'h00,
    p_hi:   8'h00,
    p_lo:   8'h00,
    mode:   M_INH,
    use_y:  1'h0,
    len:    3'h0,
    valid:  1'h0,
    ea:     16'h0000,
    target: 16'h0000,
    unauth: 1'h0,
    ill:    1'h0
  };

  // ========================================================================
  // per-mode decode helpers
  function automatic logic [1:0] ext_bytes(input apd_mode_t m);
    case (m)
      M_INH, M_IDX_0:                   ext_bytes = 2'd0;
      M_DIR_L, M_IDX_L:                 ext_bytes = 2'd2;
      M_BTB_D, M_BTB_I:                 ext_bytes = 2'd2;
      default:                          ext_bytes = 2'd1;
    endcase
  endfunction : ext_bytes

  function automatic logic [1:0] ptr_bytes(input apd_mode_t m);
    case (m)
      M_IND_L, M_IIX_L:                 ptr_bytes = 2'd2;
      M_IND_S, M_IIX_S, M_REL_I,
      M_BIT_I, M_BTB_I:                 ptr_bytes = 2'd1;
      default:                          ptr_bytes = 2'd0;
    endcase
  endfunction : ptr_bytes

  function automatic apd_base_t base_of(input apd_mode_t m);
    case (m)
      M_DIR_S, M_IDX_S, M_BIT_D, M_BTB_D: base_of = BS_B1;
      M_DIR_L, M_IDX_L:                   base_of = BS_B1B2;
      M_IND_S, M_IND_L, M_IIX_S, M_IIX_L,
      M_BIT_I, M_BTB_I:                   base_of = BS_PTR;
      default:                            base_of = BS_ZERO;
    endcase
  endfunction : base_of

  function automatic logic adds_index(input apd_mode_t m);
    adds_index = (m == M_IDX_0) || (m == M_IDX_S) || (m == M_IDX_L)
              || (m == M_IIX_S) || (m == M_IIX_L);
  endfunction : adds_index

  function automatic logic is_prebyte(input logic [7:0] b);
    is_prebyte = (b == PRE_Y_VAL) || (b == PRE_IY_VAL) || (b == PRE_IND_VAL);
  endfunction : is_prebyte

  function automatic apd_pre_t pre_of(input logic [7:0] b);
    if (b == PRE_Y_VAL) begin
      pre_of = PF_Y;
    end else if (b == PRE_IY_VAL) begin
      pre_of = PF_IND_Y;
    end else begin
      pre_of = PF_IND;
    end
  endfunction : pre_of

  // ========================================================================
  // classifier and arithmetic
  apd_mode_t   cls_mode;
  logic        cls_use_y;
  logic        cls_legal;
  logic        cls_unauth;
  logic [15:0] base;
  logic [7:0]  idx;
  logic [7:0]  rel_ofs;
  logic [15:0] ea;
  logic [15:0] target;

  apd_opclass u_opclass (
    .i_opc    (cur.opc),
    .i_pre    (cur.pre),
    .o_mode   (cls_mode),
    .o_use_y  (cls_use_y),
    .o_legal  (cls_legal),
    .o_unauth (cls_unauth)
  );

  always_comb begin
    case (base_of(cur.mode))
      BS_B1:   base = {8'h00, cur.b1};
      BS_B1B2: base = {cur.b1, cur.b2};
      // a byte pointer lives in p_lo, so short pointers stay in page zero
      BS_PTR:  base = (ptr_bytes(cur.mode) == 2'd2) ? {cur.p_hi, cur.p_lo} : {8'h00, cur.p_lo};
      default: base = 16'h0000;
    endcase
    if (!adds_index(cur.mode)) begin
      idx = 8'h00;
    end else if (cur.use_y) begin
      idx = I_Y;
    end else begin
      idx = I_X;
    end
    case (cur.mode)
      M_REL_I:          rel_ofs = cur.p_lo;
      M_BTB_D, M_BTB_I: rel_ofs = cur.b2;
      default:          rel_ofs = cur.b1;
    endcase
  end

  // pc has already moved past the last byte when the target is formed
  apd_ea_adder u_ea_adder (
    .i_base   (base),
    .i_idx    (idx),
    .i_pc     (cur.pc),
    .i_ofs    (rel_ofs),
    .o_ea     (ea),
    .o_target (target)
  );

  // ========================================================================
  // sequencer
  always_comb begin
    next_s = cur;
    next_s.ill = 1'b0;
    next_s.unauth = 1'b0;
    case (cur.st)
      S_OP: begin
        if (I_PC_LOAD) begin
          next_s.pc = I_PC_VALUE;
          next_s.pre = PF_NONE;
          next_s.len = 3'd0;
        end else if (I_MEM_ACK) begin
          next_s.pc = cur.pc + 16'h0001;
          next_s.len = cur.len + 3'd1;
          // only the first prebyte is latched; a second is taken as an opcode
          if ((cur.pre == PF_NONE) && is_prebyte(I_MEM_RDATA)) begin
            next_s.pre = pre_of(I_MEM_RDATA);
          end else begin
            next_s.opc = I_MEM_RDATA;
            next_s.st = S_DEC;
          end
        end
      end
      S_DEC: begin
        if (!cls_legal) begin
          next_s.ill = 1'b1;
          next_s.st = S_TRAP;
        end else if (cls_unauth) begin
          // dropped without reset; fetch resumes behind the opcode
          next_s.unauth = 1'b1;
          next_s.pre = PF_NONE;
          next_s.len = 3'd0;
          next_s.st = S_OP;
        end else begin
          next_s.mode = cls_mode;
          next_s.use_y = cls_use_y;
          next_s.cnt = 2'd0;
          if (ext_bytes(cls_mode) != 2'd0) begin
            next_s.st = S_OPND;
          end else begin
            next_s.st = S_FIN;
          end
        end
      end
      S_OPND: begin
        if (I_MEM_ACK) begin
          next_s.pc = cur.pc + 16'h0001;
          next_s.len = cur.len + 3'd1;
          if (cur.cnt == 2'd0) begin
            next_s.b1 = I_MEM_RDATA;
          end else begin
            next_s.b2 = I_MEM_RDATA;
          end
          if (cur.cnt + 2'd1 == ext_bytes(cur.mode)) begin
            next_s.cnt = 2'd0;
            next_s.st = (ptr_bytes(cur.mode) != 2'd0) ? S_PTR : S_FIN;
          end else begin
            next_s.cnt = cur.cnt + 2'd1;
          end
        end
      end
      S_PTR: begin
        // word pointers are stored high byte first
        if (I_MEM_ACK) begin
          if ((ptr_bytes(cur.mode) == 2'd2) && (cur.cnt == 2'd0)) begin
            next_s.p_hi = I_MEM_RDATA;
          end else begin
            next_s.p_lo = I_MEM_RDATA;
          end
          if (cur.cnt + 2'd1 == ptr_bytes(cur.mode)) begin
            next_s.st = S_FIN;
          end else begin
            next_s.cnt = cur.cnt + 2'd1;
          end
        end
      end
      S_FIN: begin
        // index registers are sampled here, after every byte is in
        next_s.ea = ea;
        next_s.target = target;
        next_s.valid = 1'b1;
        next_s.pre = PF_NONE;
        next_s.st = S_OUT;
      end
      S_OUT: begin
        if (I_EXEC_READY) begin
          next_s.valid = 1'b0;
          next_s.len = 3'd0;
          next_s.st = S_OP;
          if (I_PC_LOAD) begin
            next_s.pc = I_PC_VALUE;
          end
        end
      end
      default: begin
        // parked until the system reset that was requested comes back
        next_s.st = S_TRAP;
      end
    endcase
    if (next_s.st == S_PTR) begin
      next_s.addr = {8'h00, next_s.b1} + {14'h0000, next_s.cnt};
    end else begin
      next_s.addr = next_s.pc;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cur <= IDLE_STATE;
    end else begin
      cur <= next_s;
    end
  end

  // ========================================================================
  // outputs
  assign O_MEM_REQ     = ((cur.st == S_OP) && !I_PC_LOAD) || (cur.st == S_OPND) || (cur.st == S_PTR);
  assign O_MEM_ADDR    = cur.addr;
  assign O_DEC_VALID   = cur.valid;
  assign O_DEC_OPCODE  = cur.opc;
  assign O_DEC_MODE    = cur.mode;
  assign O_DEC_USE_Y   = cur.use_y;
  assign O_DEC_EA      = cur.ea;
  assign O_DEC_OPERAND = cur.b1;
  assign O_DEC_TARGET  = cur.target;
  assign O_DEC_NEXT_PC = cur.pc;
  assign O_DEC_LEN     = cur.len;
  assign O_DEC_UNAUTH  = cur.unauth;
  assign O_ILLEGAL_RST = cur.ill;

endmodule : apd_decoder
`default_nettype wire

// >>> testbench/apd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// program and data memory on the decoder read bus, with wait states
module apd_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic [1:0]  i_wait,
  output logic             o_ack,
  output logic      [7:0]  o_rdata
);
  logic [7:0] store [0:65535];
  logic [1:0] wait_cnt;
  logic [7:0] last;
  // idle bus shows the inverse of the last byte, so stale reads are caught
  assign o_ack   = i_req && (wait_cnt == 2'h0);
  assign o_rdata = o_ack ? store[i_addr] : ~last;
  initial begin
    for (int a = 0; a < 65536; a++) store[a] = 8'h80;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_cnt <= 2'h0;
      last     <= 8'h00;
    end else if (o_ack) begin
      wait_cnt <= i_wait;
      last     <= store[i_addr];
    end else if (i_req && wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule : apd_mem_model
`default_nettype wire

// >>> testbench/apd_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port-level checks of the decoder
module apd_decoder_properties
  import apd_pkg::*;
#(
  parameter logic [15:0] START_PC = RESET_PC
) (
  input wire logic        I_CLK,
  input wire logic        I_SYS_RST,
  input wire logic        O_MEM_REQ,
  input wire logic [15:0] O_MEM_ADDR,
  input wire logic        I_MEM_ACK,
  input wire logic        I_PC_LOAD,
  input wire logic        I_EXEC_READY,
  input wire logic        O_DEC_VALID,
  input wire apd_pkg::apd_mode_t O_DEC_MODE,
  input wire logic        O_DEC_USE_Y,
  input wire logic [15:0] O_DEC_EA,
  input wire logic [7:0]  O_DEC_OPERAND,
  input wire logic [15:0] O_DEC_TARGET,
  input wire logic [15:0] O_DEC_NEXT_PC,
  input wire logic [2:0]  O_DEC_LEN,
  input wire logic        O_DEC_UNAUTH,
  input wire logic        O_ILLEGAL_RST
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ========================================================================
  // fetch side
  chk_start_addr: assert property ($fell(I_SYS_RST) |-> O_MEM_ADDR == START_PC)
    else $error("first fetch not at start address");
  chk_req_hold: assert property (O_MEM_REQ && !I_MEM_ACK |=> $stable(O_MEM_ADDR))
    else $error("fetch address moved before ack");
  // ========================================================================
  // decode side
  chk_valid_hold: assert property (O_DEC_VALID && !I_EXEC_READY |=> O_DEC_VALID && $stable(O_DEC_EA))
    else $error("decode result not held while stalled");
  chk_take_next: assert property (O_DEC_VALID && I_EXEC_READY && !I_PC_LOAD
    |=> !O_DEC_VALID && O_MEM_ADDR == $past(O_DEC_NEXT_PC)) else $error("next fetch not at next pc");
  chk_len_range: assert property (O_DEC_VALID |-> O_DEC_LEN inside {[3'h1:3'h4]})
    else $error("instruction length out of range");
  chk_rel_target: assert property (O_DEC_VALID && O_DEC_MODE == M_REL_D
    |-> O_DEC_TARGET == O_DEC_NEXT_PC + {{8{O_DEC_OPERAND[7]}}, O_DEC_OPERAND}) else $error("bad relative target");
  chk_dir_short: assert property (O_DEC_VALID && O_DEC_MODE == M_DIR_S
    |-> O_DEC_EA == {8'h00, O_DEC_OPERAND} && O_DEC_LEN == 3'h2) else $error("bad short direct address");
  chk_dir_long: assert property (O_DEC_VALID && O_DEC_MODE == M_DIR_L
    |-> O_DEC_EA[15:8] == O_DEC_OPERAND && O_DEC_LEN == 3'h3) else $error("bad long direct address");
  chk_idx_zero: assert property (O_DEC_VALID && O_DEC_MODE == M_IDX_0
    |-> O_DEC_EA[15:8] == 8'h00 && O_DEC_LEN == (O_DEC_USE_Y ? 3'h2 : 3'h1)) else $error("bad no-offset index");
  chk_trap_park: assert property (O_ILLEGAL_RST |=> (!O_MEM_REQ && !O_DEC_VALID && !O_ILLEGAL_RST) [*4])
    else $error("decoder not parked after illegal opcode");
  chk_unauth_safe: assert property (O_DEC_UNAUTH |-> !O_ILLEGAL_RST ##1 !O_ILLEGAL_RST)
    else $error("unauthorized pair raised a reset");
  cov_unauth: cover property (O_DEC_UNAUTH);
  cov_trap: cover property (O_ILLEGAL_RST);
  cov_iy_long: cover property (O_DEC_VALID && O_DEC_MODE == M_IIX_L && O_DEC_USE_Y);
endmodule : apd_decoder_properties

bind apd_decoder apd_decoder_properties #(.START_PC(START_PC)) u_props (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .O_MEM_REQ(O_MEM_REQ), .O_MEM_ADDR(O_MEM_ADDR),
  .I_MEM_ACK(I_MEM_ACK), .I_PC_LOAD(I_PC_LOAD), .I_EXEC_READY(I_EXEC_READY), .O_DEC_VALID(O_DEC_VALID),
  .O_DEC_MODE(O_DEC_MODE), .O_DEC_USE_Y(O_DEC_USE_Y), .O_DEC_EA(O_DEC_EA), .O_DEC_OPERAND(O_DEC_OPERAND),
  .O_DEC_TARGET(O_DEC_TARGET), .O_DEC_NEXT_PC(O_DEC_NEXT_PC), .O_DEC_LEN(O_DEC_LEN),
  .O_DEC_UNAUTH(O_DEC_UNAUTH), .O_ILLEGAL_RST(O_ILLEGAL_RST));
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// instruction streams through the decoder, checked against worked addresses
module tb_top;
  import apd_pkg::*;
  localparam int NI = 25;
  logic             clk = 1'b0, rst = 1'b1, pc_load = 1'b0, ready = 1'b0;
  logic      [7:0]  x = 8'h00, y = 8'h00;
  logic      [1:0]  wsel = 2'h0;
  logic      [15:0] pc_value = 16'h0000, pc, lfsr = 16'h9b67;
  wire logic        req, ack, valid, use_y, unauth, ill;
  wire logic [7:0]  rdata, opcode, operand;
  wire logic [15:0] addr, ea, target, next_pc;
  wire logic [2:0]  len;
  apd_mode_t        mode;
  int               mismatches = 0, checks_done = 0;
  // ========================================================================
  // instruction table: prebyte (00 = none), opcode, mode, length
  logic [7:0] tpre [NI] = '{8'h00, 8'h90, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00, 8'h90, 8'h00, 8'h90,
                            8'h92, 8'h92, 8'h92, 8'h91, 8'h92, 8'h91, 8'h00, 8'h92, 8'h00, 8'h92,
                            8'h00, 8'h92, 8'h00, 8'h92};
  logic [7:0] topc [NI] = '{8'ha6, 8'hae, 8'hb6, 8'h3a, 8'hc6, 8'hf6, 8'hf6, 8'he6, 8'he6, 8'hd6, 8'hd6,
                            8'hb6, 8'hc6, 8'he6, 8'he6, 8'hd6, 8'hd6, 8'h27, 8'h27, 8'h93, 8'h93,
                            8'h15, 8'h15, 8'h05, 8'h05};
  apd_mode_t  tmod [NI] = '{M_IMM, M_IMM, M_DIR_S, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_0, M_IDX_S, M_IDX_S,
                            M_IDX_L, M_IDX_L, M_IND_S, M_IND_L, M_IIX_S, M_IIX_S, M_IIX_L, M_IIX_L,
                            M_REL_D, M_REL_I, M_REL_D, M_REL_I, M_BIT_D, M_BIT_I, M_BTB_D, M_BTB_I};
  logic [2:0] tlen [NI] = '{3'h2, 3'h3, 3'h2, 3'h2, 3'h3, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h3, 3'h3,
                            3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h3, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};
  logic [7:0] ob1 [NI], ob2 [NI];
  // long jump/call forms do not exist, so cc and dd are illegal like 9f
  logic [7:0]  bad_op [3]   = '{8'hcc, 8'hdd, 8'h9f};
  logic [15:0] bad_pair [3] = '{16'h903a, 16'h9292, 16'h91b6};

  always #50 clk = ~clk;

  apd_decoder #(.START_PC(16'h0100)) DUT (
    .I_CLK(clk), .I_SYS_RST(rst), .O_MEM_REQ(req), .O_MEM_ADDR(addr), .I_MEM_ACK(ack),
    .I_MEM_RDATA(rdata), .I_X(x), .I_Y(y), .I_PC_LOAD(pc_load), .I_PC_VALUE(pc_value),
    .I_EXEC_READY(ready), .O_DEC_VALID(valid), .O_DEC_OPCODE(opcode), .O_DEC_MODE(mode),
    .O_DEC_USE_Y(use_y), .O_DEC_EA(ea), .O_DEC_OPERAND(operand), .O_DEC_TARGET(target),
    .O_DEC_NEXT_PC(next_pc), .O_DEC_LEN(len), .O_DEC_UNAUTH(unauth), .O_ILLEGAL_RST(ill));
  apd_mem_model u_mem (.i_clk(clk), .i_rst(rst), .i_req(req), .i_addr(addr), .i_wait(wsel),
    .o_ack(ack), .o_rdata(rdata));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  function automatic logic [15:0] exp_addr(input apd_mode_t m, input logic [7:0] b1, b2, ix,
                                           input logic [15:0] np);
    logic [15:0] p;
    // word pointer low byte sits at the 16-bit successor, so ff wraps to 0100
    p = {u_mem.store[{8'h00, b1}], u_mem.store[{8'h00, b1} + 16'h0001]};
    case (m)
      M_IMM, M_DIR_S, M_BIT_D, M_BTB_D: return {8'h00, b1};
      M_DIR_L: return {b1, b2};
      M_IDX_0: return {8'h00, ix};
      M_IDX_S: return {8'h00, b1} + {8'h00, ix};
      M_IDX_L: return {b1, b2} + {8'h00, ix};
      M_IND_S, M_BIT_I, M_BTB_I: return {8'h00, p[15:8]};
      M_IND_L: return p;
      M_IIX_S: return {8'h00, p[15:8]} + {8'h00, ix};
      M_IIX_L: return p + {8'h00, ix};
      M_REL_D: return np + {{8{b1[7]}}, b1};
      default: return np + {{8{p[15]}}, p[15:8]};
    endcase
  endfunction : exp_addr

  task automatic chk(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic place(input int i, input bit corner);
    int n;
    ob1[i] = corner ? 8'hff : lfsr[7:0];
    ob2[i] = corner ? 8'hff : lfsr[15:8];
    lfsr = nxt(lfsr);
    n = (tpre[i] != 8'h00) ? 1 : 0;
    u_mem.store[pc] = tpre[i];
    u_mem.store[pc + n] = topc[i];
    u_mem.store[pc + n + 1] = ob1[i];
    u_mem.store[pc + n + 2] = ob2[i];
    pc = pc + 16'(tlen[i]);
  endtask : place

  task automatic take(input int i, input bit load);
    int n;
    logic yi;
    logic [15:0] e, g, np;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (valid !== 1'b1 && n < 60);
    yi = (tpre[i] == 8'h90 || tpre[i] == 8'h91);
    np = pc + 16'(tlen[i]);
    e = exp_addr(tmod[i], ob1[i], ob2[i], yi ? y : x, np);
    g = (tmod[i] inside {M_REL_D, M_REL_I}) ? target : ((tmod[i] == M_IMM) ? {8'h00, operand} : ea);
    chk("valid", 16'h0001, 16'(valid));
    chk("opcode", 16'(topc[i]), 16'(opcode));
    chk("mode", 16'(tmod[i]), 16'(mode));
    chk("length", 16'(tlen[i]), 16'(len));
    chk("use_y", 16'(yi), 16'(use_y));
    chk("next_pc", np, next_pc);
    chk("address", e, g);
    if (tmod[i] inside {M_BTB_D, M_BTB_I}) chk("branch target", np + {{8{ob2[i][7]}}, ob2[i]}, target);
    pc = np;
    repeat (lfsr[1:0]) @(posedge clk);
    @(posedge clk);
    ready <= 1'b1;
    pc_load <= load;
    pc_value <= 16'h0400;
    @(posedge clk);
    ready <= 1'b0;
    pc_load <= 1'b0;
  endtask : take

  task automatic watch_pulses(input bit want_u);
    logic su, si;
    su = 1'b0;
    si = 1'b0;
    repeat (40) begin
      @(negedge clk);
      su = su | unauth;
      si = si | ill;
    end
    chk("unauth pulse", 16'(want_u), 16'(su));
    chk("illegal reset", 16'(!want_u), 16'(si));
  endtask : watch_pulses

  initial begin : main
    int r, i, a;
    for (r = 0; r < 3; r++) begin
      @(posedge clk);
      rst <= 1'b1;
      x <= r ? lfsr[7:0] : 8'hff;
      y <= r ? lfsr[15:8] : 8'hff;
      wsel <= 2'(r);
      for (a = 0; a < 256; a++) begin
        u_mem.store[a] = lfsr[7:0];
        lfsr = nxt(lfsr);
      end
      pc = 16'h0100;
      for (i = 0; i < NI; i++) place(i, r == 0);
      u_mem.store[16'h0400] = bad_pair[r][15:8];
      u_mem.store[16'h0401] = bad_pair[r][7:0];
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      pc = 16'h0100;
      for (i = 0; i < NI; i++) take(i, i == NI - 1);
      @(negedge clk);
      chk("loaded fetch", 16'h0400, addr);
      watch_pulses(1'b1);
    end
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      rst <= 1'b1;
      u_mem.store[16'h0100] = bad_op[i];
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      watch_pulses(1'b0);
    end
    give_verdict;
  end

  initial begin : watchdog
    #2000000;
    mismatches++;
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
